/* File: fldc_link_model.sv */
`timescale 1ns/1ps
// far-side partner: drops the link when asked and holds it down until the bench re-arms it
module fldc_link_model (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // requests from the block
    input  wire logic partner_drop,
    input  wire logic link_drop,
    // bench commands
    input  wire logic link_req,
    input  wire logic sig_req,
    // line state seen by the block
    output logic      link_up,
    output logic      signal_present
);
    logic dropped_ff;

    // a drop request takes the link down until link_req is lowered
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dropped_ff <= 1'b0;
        else if (!link_req)
            dropped_ff <= 1'b0;
        else if (link_drop || partner_drop)
            dropped_ff <= 1'b1;
    end

    // line state outputs
    assign link_up        = link_req && !dropped_ff;
    assign signal_present = sig_req;
endmodule : fldc_link_model

/* File: fldc_neg_timer.sv */
`timescale 1ns/1ps
// counts the serial negotiation window selected by the two-bit timer field
module fldc_neg_timer
    import fldc_pkg::*;
#(
    parameter int T16 = TMR_NS_16MS / CLK_NS,
    parameter int T2U = TMR_NS_2US / CLK_NS,
    parameter int T8U = TMR_NS_800US / CLK_NS,
    parameter int T11 = TMR_NS_11MS / CLK_NS
)
(
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // control
    input  wire logic       start,
    input  wire logic [1:0] sel,
    // status
    output logic            busy,
    output logic            done
);
    initial
    begin
        if (T2U < 1 || T16 >= (1 << 24))
            $error("timer counts out of range");
    end

    logic [23:0] cnt_ff;
    logic [23:0] load;

    // duration table
    always_comb
    begin
        case (sel)
            2'h3:    load = 24'(T11);
            2'h2:    load = 24'(T8U);
            2'h1:    load = 24'(T2U);
            default: load = 24'(T16);
        endcase
    end

    // down counter, done pulses on expiry
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_ff <= 24'h0;
            done   <= 1'b0;
        end
        else
        begin
            done <= (cnt_ff == 24'h1);
            if (start)
                cnt_ff <= load;
            else if (cnt_ff != 24'h0)
                cnt_ff <= cnt_ff - 24'h1;
        end
    end

    assign busy = (cnt_ff != 24'h0);
endmodule : fldc_neg_timer

/* File: fldc_pkg.sv */
package fldc_pkg;
    // register indices (byte address is four times the index)
    localparam logic [7:0]  IDX_DROP_CFG   = 8'h2d;
    localparam logic [7:0]  IDX_DROP_THR   = 8'h2e;
    localparam logic [7:0]  IDX_MISC_MISC_CONFIG_FOUR  = 8'h31;
    localparam logic [7:0]  IDX_IRQ_STAT   = 8'h40;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'h41;
    // drop config fields
    localparam int          FORCE_DROP_BIT = 15;
    localparam int          FAST_EN_BIT    = 14;
    localparam int          CAUSE_LSB      = 8;
    localparam int          NSRC           = 5;
    localparam int          SRC_ENERGY     = 0;
    // threshold register
    localparam logic [2:0]  THR_RST        = 3'h1;
    localparam logic [2:0]  THR_STRAP_RST  = 3'h2;
    localparam logic [2:0]  RSV_THR_RST    = 3'h2;
    localparam int          THR_HI_LSB     = 8;
    localparam int          THR_MID_LSB    = 4;
    // misc config four fields
    localparam int          TEST_BIT       = 7;
    localparam int          TMR_LSB        = 5;
    localparam logic [1:0]  TMR_RST        = 2'h1;
    localparam int          RSV8_BIT       = 8;
    localparam int          RSV12_BIT      = 12;
    localparam logic [3:0]  MISC_RSV_VAL   = 4'h8;
    localparam int          MISC_RSV_LSB   = 1;
    // receive-control strap modes
    localparam logic [1:0]  RXC_MODE1      = 2'h1;
    localparam logic [1:0]  RXC_MODE2      = 2'h2;
    // negotiation timer durations in ns
    localparam int          TMR_NS_16MS    = 16000000;
    localparam int          TMR_NS_2US     = 2000;
    localparam int          TMR_NS_800US   = 800000;
    localparam int          TMR_NS_11MS    = 11000000;
    localparam int          CLK_NS         = 5;
    // ahb
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ     = 2'h3;
endpackage : fldc_pkg

/* File: fldc_top.sv */
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
// Contract
// [R1] force-drop bit makes partner drop link while no signal is received
// [R2] software keeps fast-drop enable zero until link is up
// [R3] cause bits latch when source active, enabled and dropping the link
// [R4] cause bits: 12 descrambler, 11 rx err, 10 mlt3, 9 snr, 8 energy
// [R5] five source enables, bit 4 descrambler down to bit 0 energy
// [R6] energy loss when accumulator below threshold, threshold resets to one
// [R7] strap-enabled fast drop makes threshold default two
// [R8] software rewrites threshold to one after strap enable
// [R9] receive strap mode1/mode2 sets test bit; clearing it leaves test
// [R10] software clears test bit whenever it reads one
// [R11] timer field selects 16ms, 2us, 800us, 11ms; resets to 01
// [R12] port mirror bit enables mirroring, reset value from strap
// [R13] misc bits 4:1 ignore writes and read 1000
// [R14] cause bits clear on status read unless condition persists
module fldc_top
    import fldc_pkg::*;
#(
    parameter int ACC_W = 8
)
(
    // ahb-lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // straps (pins)
    input  wire logic        strap_fast_drop,
    input  wire logic [1:0]  strap_rx_ctrl,
    input  wire logic        strap_mirror,
    // link monitors (pins)
    input  wire logic        link_up,
    input  wire logic        signal_present,
    input  wire logic [3:0]  src_fault,
    input  wire logic [ACC_W-1:0] energy_acc,
    input  wire logic        neg_start,
    // control outputs
    output logic             partner_drop,
    output logic             link_drop,
    output logic             test_mode,
    output logic             mirror_en,
    output logic             neg_busy,
    output logic             irq
);
    initial
    begin
        if (ACC_W < 3)
            $error("energy accumulator narrower than threshold");
    end

    // pin synchronisers
    logic [1:0]        s1_ff, s2_ff;
    logic [ACC_W-1:0]  acc1_ff, acc2_ff;
    logic [3:0]        flt1_ff, flt2_ff;
    logic [1:0]        rx1_ff, rx2_ff;
    logic [1:0]        ns1_ff, ns2_ff;
    logic              st1_ff, st2_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_ff <= 2'h0; s2_ff <= 2'h0;
            acc1_ff <= '0; acc2_ff <= '0;
            flt1_ff <= 4'h0; flt2_ff <= 4'h0;
            rx1_ff <= 2'h0; rx2_ff <= 2'h0;
            ns1_ff <= 2'h0; ns2_ff <= 2'h0;
            st1_ff <= 1'b0; st2_ff <= 1'b0;
        end
        else
        begin
            s1_ff   <= {link_up, signal_present};
            s2_ff   <= s1_ff;
            acc1_ff <= energy_acc;
            acc2_ff <= acc1_ff;
            flt1_ff <= src_fault;
            flt2_ff <= flt1_ff;
            rx1_ff  <= strap_rx_ctrl;
            rx2_ff  <= rx1_ff;
            ns1_ff  <= {neg_start, strap_fast_drop};
            ns2_ff  <= ns1_ff;
            st1_ff  <= strap_mirror;
            st2_ff  <= st1_ff;
        end
    end
    wire link_s   = s2_ff[1];
    wire sig_s    = s2_ff[0];
    wire fdstrap  = ns2_ff[0];
    wire nstart_s = ns2_ff[1];
    wire mir_s    = st2_ff;

    // ahb address phase capture
    logic        wr_ff, rd_ff;
    logic [7:0]  idx_ff;
    wire         take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ff  <= 1'b0;
            rd_ff  <= 1'b0;
            idx_ff <= 8'h0;
        end
        else
        begin
            wr_ff  <= take && hwrite;
            rd_ff  <= take && !hwrite;
            idx_ff <= haddr[9:2];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    wire wr_cfg  = wr_ff && hit(idx_ff, IDX_DROP_CFG);
    wire wr_thr  = wr_ff && hit(idx_ff, IDX_DROP_THR);
    wire wr_misc = wr_ff && hit(idx_ff, IDX_MISC_MISC_CONFIG_FOUR);
    wire wr_mask = wr_ff && hit(idx_ff, IDX_IRQ_MASK);
    wire rd_cfg  = take && !hwrite && hit(haddr[9:2], IDX_DROP_CFG);
    wire rd_irq  = take && !hwrite && hit(haddr[9:2], IDX_IRQ_STAT);

    // strap capture once the pin synchronisers hold the strap levels
    logic [2:0] strap_age_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            strap_age_ff <= 3'h0;
        else
            strap_age_ff <= {strap_age_ff[1:0], 1'b1};
    end
    wire strap_load = strap_age_ff[1] && !strap_age_ff[2]; // third edge after release

    // drop configuration register
    logic             force_ff, fast_en_ff;
    logic [NSRC-1:0]  src_sel_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            force_ff   <= 1'b0;
            fast_en_ff <= 1'b0;
            src_sel_ff <= '0;
        end
        else if (strap_load)
            fast_en_ff <= fdstrap;
        else if (wr_cfg)
        begin
            force_ff   <= hwdata[FORCE_DROP_BIT];
            fast_en_ff <= hwdata[FAST_EN_BIT]; // [R2]
            src_sel_ff <= hwdata[NSRC-1:0]; // [R5]
        end
    end

    // threshold register
    logic [2:0] thr_ff, rsv_hi_ff, rsv_mid_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            thr_ff     <= THR_RST; // [R6]
            rsv_hi_ff  <= RSV_THR_RST;
            rsv_mid_ff <= RSV_THR_RST;
        end
        else if (strap_load)
        begin
            if (fdstrap)
                thr_ff <= THR_STRAP_RST; // [R7]
        end
        else if (wr_thr)
        begin
            thr_ff     <= hwdata[2:0]; // [R8]
            rsv_hi_ff  <= hwdata[THR_HI_LSB +: 3];
            rsv_mid_ff <= hwdata[THR_MID_LSB +: 3];
        end
    end

    // misc config four register
    logic       test_ff, mir_ff, rsv8_ff;
    logic [1:0] tmr_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            test_ff <= 1'b0;
            mir_ff  <= 1'b0;
            rsv8_ff <= 1'b0;
            tmr_ff  <= TMR_RST; // [R11]
        end
        else if (strap_load)
        begin
            test_ff <= (rx2_ff == RXC_MODE1) || (rx2_ff == RXC_MODE2); // [R9]
            mir_ff  <= mir_s; // [R12]
        end
        else if (wr_misc)
        begin
            test_ff <= hwdata[TEST_BIT]; // [R9] [R10]
            tmr_ff  <= hwdata[TMR_LSB +: 2]; // [R11]
            rsv8_ff <= hwdata[RSV8_BIT];
            mir_ff  <= hwdata[0]; // [R12]
        end
    end
    assign test_mode = test_ff;
    assign mirror_en = mir_ff;

    // drop sources, energy source compares accumulator with threshold
    logic [NSRC-1:0] src_act;
    always_comb
    begin
        src_act = {flt2_ff, 1'b0};
        src_act[SRC_ENERGY] = (acc2_ff < ACC_W'(thr_ff)); // [R6]
    end
    wire [NSRC-1:0] drop_vec = src_act & src_sel_ff & {NSRC{fast_en_ff && link_s}};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            link_drop <= 1'b0;
        else
            link_drop <= |drop_vec;
    end

    // cause latch, set wins over read-clear
    logic [NSRC-1:0] cause_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cause_ff <= '0; // [R3]
        else if (rd_cfg)
            cause_ff <= drop_vec; // [R14]
        else
            cause_ff <= cause_ff | drop_vec; // [R3] [R4]
    end

    // partner drop forced while no signal is received
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            partner_drop <= 1'b0;
        else
            partner_drop <= force_ff && !sig_s; // [R1]
    end

    // negotiation timer
    fldc_neg_timer u_tmr
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (nstart_s),
        .sel     (tmr_ff), // [R11]
        .busy    (neg_busy),
        .done    ()
    );

    // interrupt status and mask: bit per new cause latch
    logic [NSRC-1:0] ist_ff, imask_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ist_ff <= '0;
        else if (rd_irq)
            ist_ff <= drop_vec;
        else
            ist_ff <= ist_ff | drop_vec;
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            imask_ff <= '0;
        else if (wr_mask)
            imask_ff <= hwdata[NSRC-1:0];
    end
    assign irq = |(ist_ff & imask_ff);

    // read mux registered into data phase
    logic [31:0] rdat;
    always_comb
    begin
        rdat = 32'h0;
        case (haddr[9:2])
            IDX_DROP_CFG:
            begin
                rdat[FORCE_DROP_BIT] = force_ff;
                rdat[FAST_EN_BIT]    = fast_en_ff;
                rdat[CAUSE_LSB +: NSRC] = cause_ff; // [R4]
                rdat[NSRC-1:0]       = src_sel_ff;
            end
            IDX_DROP_THR:
                rdat[15:0] = {5'h0, rsv_hi_ff, 1'b0, rsv_mid_ff, 1'b0, thr_ff};
            IDX_MISC_MISC_CONFIG_FOUR:
            begin
                rdat[RSV12_BIT] = 1'b1;
                rdat[RSV8_BIT]  = rsv8_ff;
                rdat[TEST_BIT]  = test_ff;
                rdat[TMR_LSB +: 2] = tmr_ff;
                rdat[MISC_RSV_LSB +: 4] = MISC_RSV_VAL; // [R13]
                rdat[0] = mir_ff;
            end
            IDX_IRQ_STAT: rdat[NSRC-1:0] = ist_ff;
            IDX_IRQ_MASK: rdat[NSRC-1:0] = imask_ff;
            default: rdat = 32'h0;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (take && !hwrite)
            hrdata <= rdat;
    end

    // checks
    property p_force;
        @(posedge hclk) disable iff (!hresetn)
        (force_ff && !sig_s) |=> partner_drop;
    endproperty
    a_force: assert property (p_force) else $error("partner drop missing"); // [R1]

    property p_latch;
        @(posedge hclk) disable iff (!hresetn)
        drop_vec[SRC_ENERGY] |=> cause_ff[SRC_ENERGY];
    endproperty
    a_latch: assert property (p_latch) else $error("energy cause not latched"); // [R3]

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        (cause_ff[NSRC-1] && !rd_cfg) |=> cause_ff[NSRC-1];
    endproperty
    a_hold: assert property (p_hold) else $error("cause lost without read"); // [R14]

    property p_clr;
        @(posedge hclk) disable iff (!hresetn)
        (rd_cfg && drop_vec == '0) |=> cause_ff == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("cause not cleared by read"); // [R14]

    property p_ensel;
        @(posedge hclk) disable iff (!hresetn)
        (!fast_en_ff || src_sel_ff == '0) |=> !link_drop;
    endproperty
    a_ensel: assert property (p_ensel) else $error("drop while disabled"); // [R5]

    property p_energy;
        @(posedge hclk) disable iff (!hresetn)
        (fast_en_ff && link_s && src_sel_ff[SRC_ENERGY] && acc2_ff < ACC_W'(thr_ff))
            |=> link_drop;
    endproperty
    a_energy: assert property (p_energy) else $error("energy drop missing"); // [R6]

    property p_rsv;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr[9:2] == IDX_MISC_MISC_CONFIG_FOUR)
            |=> hrdata[MISC_RSV_LSB +: 4] == MISC_RSV_VAL;
    endproperty
    a_rsv: assert property (p_rsv) else $error("misc reserved field wrong"); // [R13]

    property p_testwr;
        @(posedge hclk) disable iff (!hresetn)
        (wr_misc && !strap_load && !hwdata[TEST_BIT]) |=> !test_mode;
    endproperty
    a_testwr: assert property (p_testwr) else $error("test bit not cleared"); // [R9]

    property p_mirror;
        @(posedge hclk) disable iff (!hresetn)
        (wr_misc && !strap_load) |=> mirror_en == $past(hwdata[0]);
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror bit not written"); // [R12]
endmodule : fldc_top

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import fldc_pkg::*;
    typedef struct {
        logic [7:0]  idx;
        logic [15:0] wd;
        logic [15:0] rd;
        logic [1:0]  pins;
    } fldc_row_t;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans, strap_rx_ctrl;
    logic [2:0]  hsize;
    logic        strap_fast_drop, strap_mirror, link_up, signal_present, neg_start;
    logic [3:0]  src_fault;
    logic [7:0]  energy_acc;
    logic        partner_drop, link_drop, test_mode, mirror_en, neg_busy, irq;
    logic        link_req, sig_req;
    int          n_errors, checks_done, i, cnt;
    // register cases: index, write data, read back, {mirror_en, test_mode}
    fldc_row_t rows[9] = '{
        '{IDX_DROP_CFG, 16'hffff, 16'hc01f, 2'h0},
        '{IDX_DROP_CFG, 16'h0000, 16'h0000, 2'h0},
        '{IDX_DROP_THR, 16'hffff, 16'h0777, 2'h0},
        '{IDX_DROP_THR, 16'h0001, 16'h0001, 2'h0},
        '{IDX_MISC_MISC_CONFIG_FOUR, 16'hffff, 16'h11f1, 2'h3},
        '{IDX_MISC_MISC_CONFIG_FOUR, 16'h0000, 16'h1010, 2'h0},
        '{IDX_MISC_MISC_CONFIG_FOUR, 16'h0041, 16'h1051, 2'h2},
        '{IDX_MISC_MISC_CONFIG_FOUR, 16'h0020, 16'h1030, 2'h0},
        '{8'h30, 16'hffff, 16'h0000, 2'h0}
    };

    fldc_top fldc_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .strap_fast_drop(strap_fast_drop), .strap_rx_ctrl(strap_rx_ctrl),
        .strap_mirror(strap_mirror), .link_up(link_up), .signal_present(signal_present),
        .src_fault(src_fault), .energy_acc(energy_acc), .neg_start(neg_start),
        .partner_drop(partner_drop), .link_drop(link_drop), .test_mode(test_mode),
        .mirror_en(mirror_en), .neg_busy(neg_busy), .irq(irq)
    );
    fldc_link_model fldc_link_model_inst (
        .hclk(hclk), .hresetn(hresetn), .partner_drop(partner_drop), .link_drop(link_drop),
        .link_req(link_req), .sig_req(sig_req), .link_up(link_up),
        .signal_present(signal_present)
    );

    // clock
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // compare and count
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            n_errors++;
        end
    endtask : chk

    // one single-word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask : bus

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0);
        chk(name, {16'h0, exp}, rdv);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : rd_chk

    // reset pulse, straps held from before it
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
    endtask : do_reset

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // watchdog against a hung handshake
    initial
    begin
        #250000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        {hsel, hwrite, neg_start, strap_fast_drop, strap_mirror} = '0;
        {haddr, hwdata, htrans, hsize, strap_rx_ctrl, src_fault} = '0;
        energy_acc = 8'h80;
        link_req = 1'b1; // link comes up with the enable bit still zero
        sig_req = 1'b1;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        // reset values with straps low
        rd_chk("drop_config", IDX_DROP_CFG, 16'h0000);
        rd_chk("threshold", IDX_DROP_THR, 16'h0221);
        rd_chk("misc_config_four", IDX_MISC_MISC_CONFIG_FOUR, 16'h1030);
        chk("mirror and test", 2'h0, {mirror_en, test_mode});
        $display("test reset done");
        // register table
        foreach (rows[k])
        begin
            bus(1'b1, rows[k].idx, rows[k].wd);
            rd_chk("register row", rows[k].idx, rows[k].rd);
            chk("mirror and test pins", rows[k].pins, {mirror_en, test_mode});
        end
        $display("test registers done");
        // each drop source: no link_drop when disabled, latch and irq when enabled
        bus(1'b1, IDX_IRQ_MASK, 16'h001f);
        for (int s = 0; s < NSRC; s++)
        begin
            link_req <= 1'b0;
            @(posedge hclk);
            link_req <= 1'b1;
            bus(1'b1, IDX_DROP_CFG, 16'h4000);
            if (s == SRC_ENERGY)
                energy_acc <= 8'h00;
            else
                src_fault <= 4'h1 << (s - 1);
            repeat (8) @(negedge hclk);
            chk("link_drop disabled", 1'b0, link_drop);
            bus(1'b1, IDX_DROP_CFG, 16'h4000 | (16'h1 << s));
            for (i = 0; i < 20 && link_drop !== 1'b1; i++) @(negedge hclk);
            chk("link_drop enabled", 1'b1, link_drop);
            repeat (8) @(posedge hclk);
            rd_chk("cause latch", IDX_DROP_CFG, 16'h4000 | (16'h101 << s));
            chk("irq set", 1'b1, irq);
            src_fault <= 4'h0;
            energy_acc <= 8'h80;
            rd_chk("irq status", IDX_IRQ_STAT, 16'h1 << s);
            rd_chk("cause cleared", IDX_DROP_CFG, 16'h4000 | (16'h1 << s));
            @(negedge hclk);
            chk("irq cleared", 1'b0, irq);
        end
        $display("test drop sources done");
        // force partner drop only while no signal is received
        bus(1'b1, IDX_DROP_CFG, 16'h8000);
        repeat (8) @(negedge hclk);
        chk("partner_drop with signal", 1'b0, partner_drop);
        sig_req <= 1'b0;
        for (i = 0; i < 10 && partner_drop !== 1'b1; i++) @(negedge hclk);
        chk("partner_drop no signal", 1'b1, partner_drop);
        sig_req <= 1'b1;
        bus(1'b1, IDX_DROP_CFG, 16'h0000);
        $display("test force drop done");
        // negotiation window for field 01
        neg_start <= 1'b1;
        repeat (4) @(posedge hclk);
        neg_start <= 1'b0;
        for (i = 0; i < 10 && neg_busy !== 1'b1; i++) @(negedge hclk);
        for (cnt = 0; cnt < 1000 && neg_busy === 1'b1; cnt++) @(negedge hclk);
        chk("negotiation cycles in window", 1'b1, cnt >= 398 && cnt <= 410);
        $display("test timer done");
        // strap defaults, then software leaves test mode; mode 3 stays out of it
        for (int m = 1; m <= 3; m++)
        begin
            strap_fast_drop <= 1'b1;
            strap_mirror <= 1'b1;
            strap_rx_ctrl <= 2'(m);
            do_reset();
            rd_chk("strap threshold", IDX_DROP_THR, 16'h0222);
            rd_chk("strap drop_config", IDX_DROP_CFG, 16'h4000);
            rd_chk("strap misc", IDX_MISC_MISC_CONFIG_FOUR, (m == 3) ? 16'h1031 : 16'h10b1);
            chk("strap pins", (m == 3) ? 2'h2 : 2'h3, {mirror_en, test_mode});
            bus(1'b1, IDX_MISC_MISC_CONFIG_FOUR, 16'h0021);
            bus(1'b1, IDX_DROP_THR, 16'h0001);
            @(negedge hclk);
            chk("test mode left", 2'h2, {mirror_en, test_mode});
        end
        $display("test straps done");
        stop_test();
    end
endmodule : tb
